//--- hw/rpp_rx_ctrl.sv
// module: receive subaddress control word with wishbone access and message tracking
//
// Notes on behaviour
// - valid broadcast receive command sets the broadcast received flag, bit 9
// - interrupt rises only with per-subaddress bit 13 and global enable both set
// - broadcast invalid config makes address 31 commands invalid; flag has no effect
// - master reset and software reset both clear the broadcast received flag
// - acknowledge bit 8 belongs to the device; host writes leave it alone
// - with ping-pong enabled, device raises acknowledge once ping-pong is active
// - stop request bit 3 set: device drops acknowledge to confirm suspension
// - stop request cleared: device raises acknowledge again to confirm resume
// - enable high, acknowledge low: overwrite buffer chosen by bit 10, no toggle
// - host loads trailing zero count into bits 7-4; device uses it
// - pointer zero means buffer A, one buffer B; inverts after error-free message with ping-pong enabled and no overwrite
// - mode: ping-pong, else circular 2, else circular 1, else indexed single
`timescale 1ns/1ns
`default_nettype none
module rpp_rx_ctrl
    import rpp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // message events from the protocol engine
    input wire logic cmd_valid_i,
    input wire logic [4:0] cmd_rt_addr_i,
    input wire logic msg_done_i,
    input wire logic msg_ok_i,
    // buffer steering
    output logic rx_active_o,
    output logic [1:0] rx_mode_o,
    output logic rx_buffer_sel_o,
    output logic rx_overwrite_o,
    output logic [3:0] circ2_trailing_zero_count_o,
    output logic irq_o
);

    // ==========================================================
    // state
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic broadcast_interrupt_enable;
        logic [3:0] zn;
        logic pingpong_stop_request;
        logic pingpong_enable;
        logic c2;
        logic c1;
        logic gie;
        logic binv;
        logic software_reset_cmd;
        rpp_state_t state;
        rpp_mode_t mode;
    } rpp_main_state_t;

    rpp_main_state_t st_ff;
    rpp_main_state_t nxt_st;

    logic broadcast_received_flag_flag;
    logic pingpong_active_ack;
    logic data_pointer_select;
    logic cur_buf;
    logic cur_ovw;
    logic broadcast_received_flag_cmd;
    logic cmd_accept;
    logic msg_end;
    logic wr_req;
    logic rd_req;
    logic [15:0] ctrl_word;
    logic [31:0] stat_word;

    // ==========================================================
    // command qualification
    assign broadcast_received_flag_cmd = (cmd_rt_addr_i == RPP_BROADCAST_RECEIVED_FLAG_ADDR);
    // with broadcast invalid, address 31 is simply not a command for us
    assign cmd_accept = cmd_valid_i && (st_ff.state == RPP_ST_IDLE) && !(broadcast_received_flag_cmd && st_ff.binv);
    assign msg_end = msg_done_i && (st_ff.state == RPP_ST_RECV);

    assign wr_req = cyc_i && stb_i && we_i && !st_ff.ack;
    assign rd_req = cyc_i && stb_i && !we_i && !st_ff.ack;

    // ==========================================================
    // read views
    always_comb
    begin
        ctrl_word = RPP_CTRL_RESET;
        ctrl_word[RPP_IBR_BIT] = st_ff.broadcast_interrupt_enable;
        ctrl_word[RPP_DPB_BIT] = data_pointer_select;
        ctrl_word[RPP_BROADCAST_RECEIVED_FLAG_BIT] = broadcast_received_flag_flag;
        ctrl_word[RPP_PINGPONG_ACTIVE_ACK_BIT] = pingpong_active_ack;
        ctrl_word[RPP_ZN_LSB +: RPP_ZN_W] = st_ff.zn;
        ctrl_word[RPP_PINGPONG_STOP_REQUEST_BIT] = st_ff.pingpong_stop_request;
        ctrl_word[RPP_PINGPONG_ENABLE_BIT] = st_ff.pingpong_enable;
        ctrl_word[RPP_C2_BIT] = st_ff.c2;
        ctrl_word[RPP_C1_BIT] = st_ff.c1;
        stat_word = 32'h0000_0000;
        stat_word[RPP_ST_MODE_LSB +: 2] = st_ff.mode;
        stat_word[RPP_ST_BUSY_BIT] = (st_ff.state == RPP_ST_RECV);
        stat_word[RPP_ST_BUF_BIT] = cur_buf;
        stat_word[RPP_ST_OVW_BIT] = cur_ovw;
    end

    // ==========================================================
    // next state
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ack = cyc_i && stb_i && !st_ff.ack;
        nxt_st.software_reset_cmd = 1'b0;
        // bus writes; bits 15..14, 12..9 and acknowledge are not host writable
        if (wr_req)
        begin
            case (adr_i)
                RPP_CTRL_OFS:
                begin
                    if (sel_i[0])
                    begin
                        nxt_st.zn = dat_i[RPP_ZN_LSB +: RPP_ZN_W];
                        nxt_st.pingpong_stop_request = dat_i[RPP_PINGPONG_STOP_REQUEST_BIT];
                        nxt_st.pingpong_enable = dat_i[RPP_PINGPONG_ENABLE_BIT];
                        nxt_st.c2 = dat_i[RPP_C2_BIT];
                        nxt_st.c1 = dat_i[RPP_C1_BIT];
                    end
                    if (sel_i[1])
                        nxt_st.broadcast_interrupt_enable = dat_i[RPP_IBR_BIT];
                end
                RPP_CFG_OFS:
                begin
                    if (sel_i[0])
                    begin
                        nxt_st.gie = dat_i[RPP_GIE_BIT];
                        nxt_st.binv = dat_i[RPP_BINV_BIT];
                        nxt_st.software_reset_cmd = dat_i[RPP_SOFTWARE_RESET_CMD_BIT];
                    end
                end
                default:
                begin
                    nxt_st.software_reset_cmd = 1'b0;
                end
            endcase
        end
        // bus reads; unmapped addresses read zero
        if (rd_req)
        begin
            case (adr_i)
                RPP_CTRL_OFS: nxt_st.rdat = {16'h0000, ctrl_word};
                RPP_CFG_OFS: nxt_st.rdat = {29'h0000_0000, st_ff.software_reset_cmd, st_ff.binv, st_ff.gie};
                RPP_STAT_OFS: nxt_st.rdat = stat_word;
                default: nxt_st.rdat = 32'h0000_0000;
            endcase
        end
        // mode is frozen while a message runs so steering never changes midway
        if (st_ff.state == RPP_ST_IDLE)
            nxt_st.mode = rpp_decode_mode(st_ff.pingpong_enable, st_ff.c2, st_ff.c1);
        // message tracking
        case (st_ff.state)
            RPP_ST_IDLE:
            begin
                if (cmd_accept)
                begin
                    nxt_st.mode = rpp_decode_mode(st_ff.pingpong_enable, st_ff.c2, st_ff.c1);
                    nxt_st.state = RPP_ST_RECV;
                end
            end
            RPP_ST_RECV:
            begin
                if (msg_done_i)
                    nxt_st.state = RPP_ST_IDLE;
            end
            default:
            begin
                nxt_st.state = RPP_ST_IDLE;
            end
        endcase
        if (st_ff.software_reset_cmd)
            nxt_st.state = RPP_ST_IDLE;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
            st_ff.state <= RPP_ST_IDLE;
            st_ff.mode <= RPP_MODE_INDEXED;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // broadcast flag and interrupt
    rpp_broadcast_received_flag_flag u_broadcast_received_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sw_rst_i(st_ff.software_reset_cmd),
        .broadcast_received_flag_hit_i(cmd_accept && broadcast_received_flag_cmd),
        .ibr_i(st_ff.broadcast_interrupt_enable),
        .gie_i(st_ff.gie),
        .binv_i(st_ff.binv),
        .flag_o(broadcast_received_flag_flag),
        .irq_o(irq_o)
    );

    // ==========================================================
    // ping-pong handshake
    rpp_pp_handshake u_pp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sw_rst_i(st_ff.software_reset_cmd),
        .pingpong_enable_i(st_ff.pingpong_enable),
        .pingpong_stop_request_i(st_ff.pingpong_stop_request),
        .busy_i(st_ff.state == RPP_ST_RECV),
        .msg_start_i(cmd_accept),
        .msg_done_i(msg_end),
        .msg_ok_i(msg_ok_i),
        .pingpong_active_ack_o(pingpong_active_ack),
        .dpb_o(data_pointer_select),
        .cur_buf_o(cur_buf),
        .cur_ovw_o(cur_ovw)
    );

    // ==========================================================
    // outputs
    assign dat_o = st_ff.rdat;
    assign ack_o = st_ff.ack;
    assign rx_active_o = (st_ff.state == RPP_ST_RECV);
    assign rx_mode_o = st_ff.mode;
    assign rx_buffer_sel_o = cur_buf;
    assign rx_overwrite_o = cur_ovw;
    assign circ2_trailing_zero_count_o = st_ff.zn;

endmodule // rpp_rx_ctrl
`default_nettype wire

//--- inc/rpp_pkg.sv
// package: register map, field positions and buffer mode decoding of the receive control word
package rpp_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] RPP_CTRL_OFS = 8'h00;
    localparam logic [7:0] RPP_CFG_OFS = 8'h04;
    localparam logic [7:0] RPP_STAT_OFS = 8'h08;

    // ==========================================================
    // receive control word fields
    localparam int unsigned RPP_IBR_BIT = 13;
    localparam int unsigned RPP_DPB_BIT = 10;
    localparam int unsigned RPP_BROADCAST_RECEIVED_FLAG_BIT = 9;
    localparam int unsigned RPP_PINGPONG_ACTIVE_ACK_BIT = 8;
    localparam int unsigned RPP_ZN_LSB = 4;
    localparam int unsigned RPP_ZN_W = 4;
    localparam int unsigned RPP_PINGPONG_STOP_REQUEST_BIT = 3;
    localparam int unsigned RPP_PINGPONG_ENABLE_BIT = 2;
    localparam int unsigned RPP_C2_BIT = 1;
    localparam int unsigned RPP_C1_BIT = 0;
    localparam logic [15:0] RPP_CTRL_RESET = 16'h0000;

    // ==========================================================
    // configuration register fields
    localparam int unsigned RPP_GIE_BIT = 0;
    localparam int unsigned RPP_BINV_BIT = 1;
    localparam int unsigned RPP_SOFTWARE_RESET_CMD_BIT = 2;

    // ==========================================================
    // status register fields
    localparam int unsigned RPP_ST_MODE_LSB = 0;
    localparam int unsigned RPP_ST_BUSY_BIT = 2;
    localparam int unsigned RPP_ST_BUF_BIT = 3;
    localparam int unsigned RPP_ST_OVW_BIT = 4;

    // ==========================================================
    // terminal address that means broadcast
    localparam logic [4:0] RPP_BROADCAST_RECEIVED_FLAG_ADDR = 5'h1F;

    typedef enum logic [1:0] {
        RPP_MODE_INDEXED,
        RPP_MODE_CIRC1,
        RPP_MODE_CIRC2,
        RPP_MODE_PINGPONG
    } rpp_mode_t;

    typedef enum logic {
        RPP_ST_IDLE,
        RPP_ST_RECV
    } rpp_state_t;

    // ping-pong outranks circular 2, which outranks circular 1
    function automatic rpp_mode_t rpp_decode_mode(input logic pingpong_enable, input logic c2, input logic c1);
        rpp_mode_t m;
        if (pingpong_enable)
            m = RPP_MODE_PINGPONG;
        else if (c2)
            m = RPP_MODE_CIRC2;
        else if (c1)
            m = RPP_MODE_CIRC1;
        else
            m = RPP_MODE_INDEXED;
        return m;
    endfunction

endpackage

//--- hw/rpp_broadcast_received_flag_flag.sv
// module: broadcast received flag and broadcast interrupt output
`timescale 1ns/1ns
`default_nettype none
module rpp_broadcast_received_flag_flag
    import rpp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sw_rst_i,
    input wire logic broadcast_received_flag_hit_i,
    input wire logic ibr_i,
    input wire logic gie_i,
    input wire logic binv_i,
    output logic flag_o,
    output logic irq_o
);

    typedef struct packed {
        logic flag;
        logic irq;
    } rpp_bc_state_t;

    rpp_bc_state_t st_ff;
    rpp_bc_state_t nxt_st;

    // ==========================================================
    // next state
    always_comb
    begin
        nxt_st = st_ff;
        if (sw_rst_i)
            nxt_st.flag = 1'b0;
        if (broadcast_received_flag_hit_i && !binv_i)
            nxt_st.flag = 1'b1;
        // flag is meaningless while broadcast is treated as invalid
        nxt_st.irq = nxt_st.flag && ibr_i && gie_i && !binv_i;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign flag_o = st_ff.flag;
    assign irq_o = st_ff.irq;

endmodule // rpp_broadcast_received_flag_flag
`default_nettype wire

//--- hw/rpp_pp_handshake.sv
// module: ping-pong acknowledge handshake and data pointer select
`timescale 1ns/1ns
`default_nettype none
module rpp_pp_handshake
    import rpp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sw_rst_i,
    input wire logic pingpong_enable_i,
    input wire logic pingpong_stop_request_i,
    input wire logic busy_i,
    input wire logic msg_start_i,
    input wire logic msg_done_i,
    input wire logic msg_ok_i,
    output logic pingpong_active_ack_o,
    output logic dpb_o,
    output logic cur_buf_o,
    output logic cur_ovw_o
);

    typedef struct packed {
        logic pingpong_active_ack;
        logic data_pointer_select;
        logic cur_buf;
        logic cur_ovw;
    } rpp_pp_state_t;

    rpp_pp_state_t st_ff;
    rpp_pp_state_t nxt_st;

    // ==========================================================
    // next state
    always_comb
    begin
        nxt_st = st_ff;
        // acknowledge only moves between messages so a message never changes mode midway
        if (!busy_i && !msg_start_i)
            nxt_st.pingpong_active_ack = pingpong_enable_i && !pingpong_stop_request_i;
        if (msg_start_i)
        begin
            nxt_st.cur_buf = st_ff.data_pointer_select;
            nxt_st.cur_ovw = pingpong_enable_i && !st_ff.pingpong_active_ack;
        end
        if (msg_done_i && msg_ok_i && pingpong_enable_i && !st_ff.cur_ovw)
            nxt_st.data_pointer_select = !st_ff.data_pointer_select;
        if (sw_rst_i)
            nxt_st.data_pointer_select = 1'b0;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign pingpong_active_ack_o = st_ff.pingpong_active_ack;
    assign dpb_o = st_ff.data_pointer_select;
    assign cur_buf_o = st_ff.cur_buf;
    assign cur_ovw_o = st_ff.cur_ovw;

endmodule // rpp_pp_handshake
`default_nettype wire

//--- verif/rpp_rx_ctrl_chk.sv
// checker: port properties of the receive control word block
`timescale 1ns/1ns
`default_nettype none
module rpp_rx_ctrl_chk
    import rpp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic cmd_valid_i,
    input wire logic [4:0] cmd_rt_addr_i,
    input wire logic msg_done_i,
    input wire logic msg_ok_i,
    input wire logic rx_active_o,
    input wire logic [1:0] rx_mode_o,
    input wire logic rx_buffer_sel_o,
    input wire logic rx_overwrite_o,
    input wire logic [3:0] circ2_trailing_zero_count_o,
    input wire logic irq_o
);
    // ==========
    // shadow of host writes, taken on the edge the slave takes them
    logic [15:0] ctrl_ff;
    logic [1:0] cfg_ff;
    logic sel_ff;
    logic wr;
    logic acc;
    logic pp_w;
    logic [1:0] mode_w;
    assign wr = cyc_i && stb_i && we_i && !ack_o;
    assign acc = cmd_valid_i && !rx_active_o && !(cmd_rt_addr_i == RPP_BROADCAST_RECEIVED_FLAG_ADDR && cfg_ff[RPP_BINV_BIT]);
    assign pp_w = ctrl_ff[RPP_PINGPONG_ENABLE_BIT] && !ctrl_ff[RPP_PINGPONG_STOP_REQUEST_BIT];
    assign mode_w = ctrl_ff[RPP_PINGPONG_ENABLE_BIT] ? 2'h3 : ctrl_ff[RPP_C2_BIT] ? 2'h2 : {1'h0, ctrl_ff[RPP_C1_BIT]};
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= 16'h0000;
            cfg_ff <= 2'h0;
            sel_ff <= 1'h0;
        end
        else if (wr && adr_i == RPP_CTRL_OFS)
            ctrl_ff <= dat_i[15:0];
        else if (wr && adr_i == RPP_CFG_OFS)
        begin
            cfg_ff <= dat_i[1:0];
            if (dat_i[RPP_SOFTWARE_RESET_CMD_BIT])
                sel_ff <= 1'h0;
        end
        else if (msg_done_i && rx_active_o && msg_ok_i && rx_mode_o == 2'h3 && !rx_overwrite_o)
            sel_ff <= !rx_buffer_sel_o;
    end
    // ==========
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
    property p_bc_irq; acc && cmd_rt_addr_i == RPP_BROADCAST_RECEIVED_FLAG_ADDR && ctrl_ff[RPP_IBR_BIT] && cfg_ff[RPP_GIE_BIT]
        |=> irq_o; endproperty
    property p_irq_gate; irq_o |-> $past(ctrl_ff[RPP_IBR_BIT]) && $past(cfg_ff[RPP_GIE_BIT])
        && !$past(cfg_ff[RPP_BINV_BIT]); endproperty
    property p_refuse; cmd_valid_i && !rx_active_o && cmd_rt_addr_i == RPP_BROADCAST_RECEIVED_FLAG_ADDR && cfg_ff[RPP_BINV_BIT]
        |=> !rx_active_o; endproperty
    property p_mode; acc |=> rx_active_o && rx_mode_o == mode_w; endproperty
    property p_stop; acc && ctrl_ff[RPP_PINGPONG_ENABLE_BIT] && ctrl_ff[RPP_PINGPONG_STOP_REQUEST_BIT] && $past(ctrl_ff[RPP_PINGPONG_STOP_REQUEST_BIT], 3)
        |=> rx_overwrite_o; endproperty
    property p_live; acc && pp_w && $past(pp_w, 3) |=> !rx_overwrite_o; endproperty
    property p_zn; ack_o && we_i && adr_i == RPP_CTRL_OFS |=> circ2_trailing_zero_count_o == ctrl_ff[7:4]; endproperty
    property p_dpb; acc |=> rx_buffer_sel_o == sel_ff; endproperty
    property p_rst; $fell(rst_i) |-> !irq_o && !rx_active_o && circ2_trailing_zero_count_o == 4'h0; endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse after request");
    a_bc_irq: assert property (p_bc_irq) else $error("broadcast did not raise irq");
    a_irq_gate: assert property (p_irq_gate) else $error("irq without both enables");
    a_refuse: assert property (p_refuse) else $error("address 31 taken while invalid");
    a_mode: assert property (p_mode) else $error("wrong buffer mode");
    a_stop: assert property (p_stop) else $error("no overwrite while stopped");
    a_live: assert property (p_live) else $error("overwrite while ping-pong live");
    a_zn: assert property (p_zn) else $error("zero count not copied");
    a_dpb: assert property (p_dpb) else $error("wrong buffer select");
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    c_pp: cover property (acc && mode_w == 2'h3 && pp_w);
    c_bc: cover property (acc && cmd_rt_addr_i == RPP_BROADCAST_RECEIVED_FLAG_ADDR);
    c_ref: cover property (cmd_valid_i && cmd_rt_addr_i == RPP_BROADCAST_RECEIVED_FLAG_ADDR && cfg_ff[RPP_BINV_BIT]);
endmodule // rpp_rx_ctrl_chk
bind rpp_rx_ctrl rpp_rx_ctrl_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .ack_o,
    .cmd_valid_i, .cmd_rt_addr_i, .msg_done_i, .msg_ok_i, .rx_active_o, .rx_mode_o, .rx_buffer_sel_o,
    .rx_overwrite_o, .circ2_trailing_zero_count_o, .irq_o);
`default_nettype wire

//--- verif/rpp_msg_src.sv
// partner: bus command source issuing receive commands and message completions
`timescale 1ns/1ns
`default_nettype none
module rpp_msg_src
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [4:0] rt_i,
    input wire logic ok_i,
    input wire logic [3:0] len_i,
    output logic cmd_valid_o,
    output logic [4:0] cmd_rt_addr_o,
    output logic msg_done_o,
    output logic msg_ok_o,
    output logic busy_o
);
    int cnt;
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_o <= 1'h0;
            cnt <= 0;
            cmd_valid_o <= 1'h0;
            msg_done_o <= 1'h0;
            cmd_rt_addr_o <= 5'h00;
            msg_ok_o <= 1'h0;
        end
        else
        begin
            cmd_valid_o <= go_i && !busy_o;
            msg_done_o <= busy_o && cnt == 2;
            // outside their strobe these lines keep changing, so no stale value can pass
            msg_ok_o <= (busy_o && cnt == 2) ? ok_i : !msg_ok_o;
            if (go_i && !busy_o)
            begin
                busy_o <= 1'h1;
                cmd_rt_addr_o <= rt_i;
                cnt <= len_i + 2;
            end
            else
            begin
                cmd_rt_addr_o <= ~cmd_rt_addr_o;
                cnt <= busy_o ? cnt - 1 : 0;
                if (busy_o && cnt == 0)
                    busy_o <= 1'h0;
            end
        end
    end
endmodule // rpp_msg_src
`default_nettype wire

//--- verif/tb_rpp_rx_ctrl.sv
// testbench: register traffic and messages checked against a reference model
`timescale 1ns/1ns
`default_nettype none
module tb_rpp_rx_ctrl
    import rpp_pkg::*;
();
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic cyc_i = 1'h0;
    logic stb_i = 1'h0;
    logic we_i = 1'h0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h00000000;
    logic go = 1'h0;
    logic ok = 1'h0;
    logic [4:0] rt = 5'h00;
    logic [3:0] len = 4'h0;
    logic [31:0] dat_o;
    logic ack_o, cmd_valid_i, msg_done_i, msg_ok_i, rx_active_o, rx_buffer_sel_o, rx_overwrite_o, irq_o, busy;
    logic [4:0] cmd_rt_addr_i;
    logic [1:0] rx_mode_o;
    logic [3:0] circ2_trailing_zero_count_o;
    // ==========
    // reference model state
    logic [15:0] ctrl;
    logic gie, binv, flag, data_pointer_select, sel_e, ovw_e, software_reset_cmd;
    logic [1:0] mode_e;
    logic [31:0] rd, r;
    logic [15:0] hs [4] = '{16'hFFFF, 16'h0004, 16'h010C, 16'h0104};
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 32'h5675;
    rpp_rx_ctrl u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .cmd_valid_i, .cmd_rt_addr_i, .msg_done_i, .msg_ok_i, .rx_active_o, .rx_mode_o, .rx_buffer_sel_o,
        .rx_overwrite_o, .circ2_trailing_zero_count_o, .irq_o);
    rpp_msg_src u_src (.clk_i, .rst_i, .go_i(go), .rt_i(rt), .ok_i(ok), .len_i(len), .cmd_valid_o(cmd_valid_i),
        .cmd_rt_addr_o(cmd_rt_addr_i), .msg_done_o(msg_done_i), .msg_ok_o(msg_ok_i), .busy_o(busy));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            fail_count++;
            $display("MISMATCH t=%0t timeout", $time);
            summarize;
        end
    end
    // ==========
    // tasks
    task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        sel_i <= 4'hF;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'h1);
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask
    task run_msg(input logic [4:0] a, input logic k);
        @(posedge clk_i);
        go <= 1'h1;
        rt <= a;
        ok <= k;
        len <= 4'($random(seed)) & 4'h3;
        @(posedge clk_i);
        go <= 1'h0;
        do @(posedge clk_i); while (busy === 1'h1);
        // refused commands leave every output except the mode, and the pointer, as they were
        if (!(a == RPP_BROADCAST_RECEIVED_FLAG_ADDR && binv))
        begin
            flag = flag | (a == RPP_BROADCAST_RECEIVED_FLAG_ADDR);
            mode_e = ctrl[2] ? 2'h3 : ctrl[1] ? 2'h2 : {1'h0, ctrl[0]};
            ovw_e = ctrl[2] && ctrl[3];
            sel_e = data_pointer_select;
            data_pointer_select = data_pointer_select ^ (mode_e == 2'h3 && k && !ovw_e);
        end
    endtask
    task check_all;
        // mode follows the enable bits whenever no message runs, refused commands included
        mode_e = ctrl[2] ? 2'h3 : ctrl[1] ? 2'h2 : {1'h0, ctrl[0]};
        wb(1'h0, RPP_CTRL_OFS, 32'h0);
        cmp(rd, {16'h0, ctrl & 16'h20FF | {5'h0, data_pointer_select, flag, ctrl[2] & !ctrl[3], 8'h00}}, "ctrl");
        wb(1'h0, RPP_STAT_OFS, 32'h0);
        cmp(rd, {27'h0, ovw_e, sel_e, 1'h0, mode_e}, "stat");
        wb(1'h0, RPP_CFG_OFS, 32'h0);
        cmp(rd, {30'h0, binv, gie}, "cfg");
        cmp({rx_active_o, rx_mode_o, rx_buffer_sel_o, rx_overwrite_o}, {1'h0, mode_e, sel_e, ovw_e}, "pins");
        cmp(circ2_trailing_zero_count_o, ctrl[7:4], "zero count");
        cmp(irq_o, flag && ctrl[13] && gie && !binv, "irq");
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========
    // main sequence
    initial
    begin
        {ctrl, gie, binv, flag, data_pointer_select, sel_e, ovw_e, mode_e} = '0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        check_all;
        wb(1'h0, 8'h0C, 32'h0);
        cmp(rd, 32'h0, "unmapped");
        $display("test reset values done");
        // set every bit, enable ping-pong, request a stop, then clear the stop request
        foreach (hs[j])
        begin
            wb(1'h1, RPP_CTRL_OFS, {16'hFFFF, hs[j]});
            ctrl = hs[j];
            check_all;
        end
        $display("test handshake done");
        for (int i = 0; i < 60; i++)
        begin
            r = $random(seed);
            software_reset_cmd = (i % 4 == 3);
            gie = r[16];
            binv = r[17] & r[18] & !software_reset_cmd;
            wb(1'h1, RPP_CTRL_OFS, r);
            ctrl = r[15:0];
            wb(1'h1, RPP_CFG_OFS, {29'h0, software_reset_cmd, binv, gie});
            flag = flag & !software_reset_cmd;
            data_pointer_select = data_pointer_select & !software_reset_cmd;
            run_msg(r[20] ? RPP_BROADCAST_RECEIVED_FLAG_ADDR : r[25:21], r[26]);
            check_all;
        end
        $display("test random messages done");
        summarize;
    end
endmodule // tb_rpp_rx_ctrl
`default_nettype wire
